// ---- rtl/osb_pkg.sv ----
// package: register map, field layout, reset values and types of the swing sequencer
package osb_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam int          AXI_AW          = 6;
    localparam logic [5:0]  ADDR_CTRL       = 6'h00;
    localparam logic [5:0]  ADDR_SUPV       = 6'h04;
    localparam logic [5:0]  ADDR_DLY_BASE   = 6'h08;
    localparam logic [5:0]  ADDR_STEP       = 6'h04;
    localparam logic [5:0]  ADDR_STATUS     = 6'h20;

    // ------------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------------
    localparam int          CTRL_EN_BIT      = 0;
    localparam int          CTRL_THREE_BIT   = 1;
    localparam int          CTRL_DELAYED_BIT = 2;
    localparam int          CTRL_TGT_LSB     = 3;
    localparam int          CTRL_EVT_BIT     = 5;
    localparam int          CTRL_SRC_LSB     = 8;
    localparam int          SRC_W            = 3;
    localparam logic [15:0] CTRL_RESET       = 16'h0004;
    localparam logic [15:0] SUPV_RESET       = 16'h0258;

    // ------------------------------------------------------------------
    // status fields
    // ------------------------------------------------------------------
    localparam int STS_BLOCK_BIT  = 0;
    localparam int STS_TRIP_BIT   = 1;
    localparam int STS_L1_BIT     = 2;
    localparam int STS_L2_BIT     = 3;
    localparam int STS_READY_BIT  = 4;
    localparam int STS_L4_BIT     = 5;
    localparam int STS_TGT_BIT    = 6;

    // ------------------------------------------------------------------
    // timers, all in milliseconds
    // ------------------------------------------------------------------
    localparam int TMR_PKP1 = 0;
    localparam int TMR_RST1 = 1;
    localparam int TMR_PKP2 = 2;
    localparam int TMR_PKP3 = 3;
    localparam int TMR_PKP4 = 4;
    localparam int TMR_HOLD = 5;
    localparam int NUM_TMR  = 6;
    localparam int DLY_W    = 16;
    localparam logic [DLY_W-1:0] DLY_RESET [NUM_TMR] = '{
        16'h001E, 16'h0032, 16'h0011, 16'h0009, 16'h0011, 16'h0190};
    localparam int TICK_NS = 1000000;
    localparam int CLK_NS  = 20;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        OSB_TGT_SELF  = 2'h0,
        OSB_TGT_LATCH = 2'h1,
        OSB_TGT_OFF   = 2'h2
    } osb_target_t;

    typedef struct packed {
        logic outer;
        logic middle;
        logic inner;
        logic supv_ok;
    } osb_zone_t;

endpackage : osb_pkg

// ---- rtl/osb_swing_seq.sv ----
// oscillation blocking and out-of-step trip sequencer with an AXI4-Lite register slave
//
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module osb_swing_seq
    import osb_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_NS / CLK_NS
) (
    input  wire logic              aclk,                  // 50 MHz clock
    input  wire logic              aresetn,               // sync reset, active low
    input  wire logic [AXI_AW-1:0] s_axi_awaddr,          // write address
    input  wire logic              s_axi_awvalid,         // write address valid
    output logic                   s_axi_awready,         // write address ready
    input  wire logic [31:0]       s_axi_wdata,           // write data
    input  wire logic [3:0]        s_axi_wstrb,           // write byte enables
    input  wire logic              s_axi_wvalid,          // write data valid
    output logic                   s_axi_wready,          // write data ready
    output logic [1:0]             s_axi_bresp,           // write response
    output logic                   s_axi_bvalid,          // write response valid
    input  wire logic              s_axi_bready,          // write response ready
    input  wire logic [AXI_AW-1:0] s_axi_araddr,          // read address
    input  wire logic              s_axi_arvalid,         // read address valid
    output logic                   s_axi_arready,         // read address ready
    output logic [31:0]            s_axi_rdata,           // read data
    output logic [1:0]             s_axi_rresp,           // read response
    output logic                   s_axi_rvalid,          // read data valid
    input  wire logic              s_axi_rready,          // read data ready
    input  wire osb_zone_t         zone,                  // zone and supervision flags
    input  wire logic              external_trip_inhibit, // forces trip low
    output logic [DLY_W-1:0]       current_supervision_pickup, // milli-pu level
    output logic [SRC_W-1:0]       source_sel,            // measurement set select
    output logic                   swing_block,           // blocking output
    output logic                   swing_trip,            // out-of-step trip
    output logic                   target_flag,           // target indication
    output logic                   event_pulse            // one-cycle event strobe
);

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [15:0]      ctrl;
    logic [DLY_W-1:0] dly [NUM_TMR];
    logic [AXI_AW-1:0] aw_addr;
    logic             aw_held;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;
    logic             w_held;
    logic             do_write;
    logic [31:0]      rd_word;
    logic             rd_hit;
    logic             wr_hit;
    logic             tgt_clear;
    logic [15:0]      tick_cnt;
    logic             ms_tick;
    logic             latch1;
    logic             latch2;
    logic             ready;
    logic             latch4;
    logic             seal;
    logic             tgt_latched;
    logic             next_block;
    logic             next_seal;
    logic             next_trip;
    logic             trip_start;
    logic [NUM_TMR-1:0] run;
    logic [NUM_TMR-1:0] done;

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0]  strb);
        logic [15:0] res;
        res = old;
        if (strb[0]) begin
            res[7:0] = data[7:0];
        end
        if (strb[1]) begin
            res[15:8] = data[15:8];
        end
        return res;
    endfunction : merge16

    // ------------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------------
    // address and data are caught separately, so either may come first
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign do_write      = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'h0;
            aw_addr <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'h1;
            aw_addr <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held <= 1'h0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'h0;
            w_data <= '0;
            w_strb <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'h1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (do_write) begin
            w_held <= 1'h0;
        end
    end

    always_comb begin
        wr_hit = (aw_addr == ADDR_CTRL) || (aw_addr == ADDR_SUPV) || (aw_addr == ADDR_STATUS);
        for (int i = 0; i < NUM_TMR; i++) begin
            if (aw_addr == ADDR_DLY_BASE + AXI_AW'(i) * ADDR_STEP) begin
                wr_hit = 1'h1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'h0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'h1;
            s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'h0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl                       <= CTRL_RESET;
            current_supervision_pickup <= SUPV_RESET;
            for (int i = 0; i < NUM_TMR; i++) begin
                dly[i] <= DLY_RESET[i];
            end
        end else if (do_write) begin
            if (aw_addr == ADDR_CTRL) begin
                ctrl <= merge16(ctrl, w_data, w_strb);
            end else if (aw_addr == ADDR_SUPV) begin
                current_supervision_pickup <= merge16(current_supervision_pickup,
                                                      w_data, w_strb);
            end else begin
                for (int i = 0; i < NUM_TMR; i++) begin
                    if (aw_addr == ADDR_DLY_BASE + AXI_AW'(i) * ADDR_STEP) begin
                        dly[i] <= merge16(dly[i], w_data, w_strb);
                    end
                end
            end
        end
    end

    assign tgt_clear = do_write && (aw_addr == ADDR_STATUS) && w_strb[0]
                       && w_data[STS_TGT_BIT];

    // ------------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------------
    always_comb begin
        rd_word = '0;
        rd_hit  = 1'h1;
        if (s_axi_araddr == ADDR_CTRL) begin
            rd_word = {16'h0000, ctrl};
        end else if (s_axi_araddr == ADDR_SUPV) begin
            rd_word = {16'h0000, current_supervision_pickup};
        end else if (s_axi_araddr == ADDR_STATUS) begin
            rd_word[STS_BLOCK_BIT] = swing_block;
            rd_word[STS_TRIP_BIT]  = swing_trip;
            rd_word[STS_L1_BIT]    = latch1;
            rd_word[STS_L2_BIT]    = latch2;
            rd_word[STS_READY_BIT] = ready;
            rd_word[STS_L4_BIT]    = latch4;
            rd_word[STS_TGT_BIT]   = target_flag;
        end else begin
            rd_hit = 1'h0;
            for (int i = 0; i < NUM_TMR; i++) begin
                if (s_axi_araddr == ADDR_DLY_BASE + AXI_AW'(i) * ADDR_STEP) begin
                    rd_word = {16'h0000, dly[i]};
                    rd_hit  = 1'h1;
                end
            end
        end
    end

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'h0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'h1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'h0;
        end
    end

    // ------------------------------------------------------------------
    // millisecond tick and zone qualification
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn || ms_tick) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= tick_cnt + 16'h0001;
        end
    end
    assign ms_tick = (tick_cnt == 16'(TICK_CYCLES - 1));

    logic en;
    logic three;
    logic delayed;
    logic outer;
    logic middle;
    logic inner;
    logic stage2;
    assign en      = ctrl[CTRL_EN_BIT];
    assign three   = ctrl[CTRL_THREE_BIT];
    assign delayed = ctrl[CTRL_DELAYED_BIT];
    assign source_sel = ctrl[CTRL_SRC_LSB +: SRC_W];
    // upstream flags are trusted to be synchronous to aclk
    assign outer  = zone.outer  && zone.supv_ok && en;
    assign middle = zone.middle && zone.supv_ok && en;
    assign inner  = zone.inner  && zone.supv_ok && en;
    assign stage2 = three ? latch2 : latch1;

    // ------------------------------------------------------------------
    // delay timers
    // ------------------------------------------------------------------
    assign run[TMR_PKP1] = outer && !(three ? middle : inner);
    assign run[TMR_RST1] = swing_block && !outer;
    assign run[TMR_PKP2] = three && latch1 && !latch2 && outer && middle && !inner;
    assign run[TMR_PKP3] = stage2 && !ready && outer && inner;
    assign run[TMR_PKP4] = delayed && ready && !latch4 && outer && !inner;
    assign run[TMR_HOLD] = seal;

    // a timer restarts whenever its condition drops, so leaving outer clears the four pickup timers
    for (genvar g = 0; g < NUM_TMR; g++) begin : g_tmr
        logic [DLY_W-1:0] cnt;
        assign done[g] = run[g] && (cnt >= dly[g]);
        always_ff @(posedge aclk) begin
            if (!aresetn || !run[g]) begin
                cnt <= '0;
            end else if (ms_tick && !done[g]) begin
                cnt <= cnt + 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------------
    // tripping latches
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn || !outer) begin
            latch1 <= 1'h0;
            latch2 <= 1'h0;
            ready  <= 1'h0;
            latch4 <= 1'h0;
        end else begin
            if (done[TMR_PKP1]) begin
                latch1 <= 1'h1;
            end
            if (done[TMR_PKP2]) begin
                latch2 <= 1'h1;
            end
            if (done[TMR_PKP3]) begin
                ready <= 1'h1;
            end
            if (done[TMR_PKP4]) begin
                latch4 <= 1'h1;
            end
        end
    end

    // delayed exit trip reads latch 4 before the same edge clears it
    assign trip_start = (!delayed && done[TMR_PKP3])
                      || (delayed && latch4 && !outer);

    always_comb begin
        next_block = swing_block;
        if (!en) begin
            next_block = 1'h0;
        end else if (done[TMR_PKP1]) begin
            next_block = 1'h1;
        end else if (done[TMR_RST1]) begin
            next_block = 1'h0;
        end
        next_seal = seal;
        if (!en) begin
            next_seal = 1'h0;
        end else if (trip_start) begin
            next_seal = 1'h1;
        end else if (done[TMR_HOLD]) begin
            next_seal = 1'h0;
        end
        // inhibit only masks the output; the sequence keeps running
        next_trip = next_seal && !external_trip_inhibit;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            swing_block <= 1'h0;
            seal        <= 1'h0;
            swing_trip  <= 1'h0;
        end else begin
            swing_block <= next_block;
            seal        <= next_seal;
            swing_trip  <= next_trip;
        end
    end

    // ------------------------------------------------------------------
    // target and events
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tgt_latched <= 1'h0;
        end else if (next_trip || next_block) begin
            tgt_latched <= 1'h1;                                      // set wins over clear
        end else if (tgt_clear) begin
            tgt_latched <= 1'h0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            target_flag <= 1'h0;
            event_pulse <= 1'h0;
        end else begin
            case (osb_target_t'(ctrl[CTRL_TGT_LSB +: 2]))
                OSB_TGT_SELF:  target_flag <= next_trip || next_block;
                OSB_TGT_LATCH: target_flag <= tgt_latched || next_trip || next_block;
                default:       target_flag <= 1'h0;
            endcase
            event_pulse <= ctrl[CTRL_EVT_BIT] && ((next_trip && !swing_trip)
                           || (next_block && !swing_block));
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_disable_quiet: assert property (!en |=> !swing_block && !swing_trip)
        else $error("block or trip while disabled");
    chk_block_pickup: assert property (en && done[TMR_PKP1] |=> swing_block)
        else $error("block not raised after pickup 1");
    chk_block_hold: assert property (en && swing_block && outer |=> swing_block)
        else $error("block dropped while inside outer");
    chk_block_drop: assert property ($fell(swing_block) && $past(en) |->
                                     $past(done[TMR_RST1]))
        else $error("block dropped before reset delay");
    chk_latch_clear: assert property (!outer |=> !latch1 && !latch2 && !ready)
        else $error("latch survived leaving outer");
    chk_two_step_skip: assert property (!three |-> !run[TMR_PKP2])
        else $error("pickup 2 stage ran in two-step");
    chk_early_trip: assert property (en && !delayed && done[TMR_PKP3] &&
                                     !external_trip_inhibit |=> swing_trip)
        else $error("early trip missing");
    chk_delayed_trip: assert property (en && delayed && latch4 && !outer &&
                                       !external_trip_inhibit |=> swing_trip)
        else $error("delayed trip missing on outer exit");
    chk_inhibit_low: assert property (external_trip_inhibit |=> !swing_trip)
        else $error("trip high under inhibit");
    chk_delayed_exit: assert property ($rose(seal) && $past(delayed) |->
                                       $past(latch4) && !$past(outer))
        else $error("delayed trip without armed exit");

    cov_block: cover property ($rose(swing_block));
    cov_early: cover property (!delayed && $rose(swing_trip));
    cov_delayed: cover property (delayed && $rose(swing_trip));
    cov_inhibit: cover property (seal && external_trip_inhibit);

endmodule : osb_swing_seq

`default_nettype wire

// ---- test/osb_zone_src.sv ----
// upstream comparator model: turns a locus depth into zone flags
`timescale 1ns/100ps
`default_nettype none

module osb_zone_src
    import osb_pkg::*;
(
    input  wire logic       aclk,    // sequencer clock
    input  wire logic       aresetn, // sync reset, active low
    input  wire logic [1:0] depth,   // 0 out, 1 outer, 2 middle, 3 inner
    input  wire logic       supv,    // current above supervision level
    output var  osb_zone_t  zone     // registered zone flags
);
    // zones nest, so a deeper locus sets every outer flag as well
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            zone <= '0;
        end else begin
            zone <= '{depth >= 2'h1, depth >= 2'h2, depth == 2'h3, supv};
        end
    end
endmodule : osb_zone_src

`default_nettype wire

// ---- test/tb.sv ----
// bench: register access and zone sequences of the swing sequencer
`timescale 1ns/100ps
`default_nettype none

module tb import osb_pkg::*; ;
    logic aclk = 1'b0, aresetn = 1'b0, external_trip_inhibit = 1'b0, supv = 1'b1;
    logic [AXI_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, swing_block, swing_trip;
    logic target_flag, event_pulse;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, r, depth = 2'h0;
    logic [DLY_W-1:0] current_supervision_pickup;
    logic [SRC_W-1:0] source_sel;
    osb_zone_t zone;
    int failures = 0, checks = 0, events = 0;
    // short delays keep the run brief; upper half of one word must be ignored
    logic [31:0] dly [NUM_TMR] = '{32'h0, 32'hFFFF0003, 32'h0, 32'h0, 32'h0, 32'h14};

    always #10 aclk = ~aclk;
    // one-cycle event strobes are counted so that none can slip past a poll
    always @(posedge aclk) begin
        if (event_pulse) events++;
    end
    osb_zone_src osb_zone_src_inst (.aclk(aclk), .aresetn(aresetn), .depth(depth),
        .supv(supv), .zone(zone));
    osb_swing_seq #(.TICK_CYCLES(4)) osb_swing_seq_inst (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .zone(zone),
        .external_trip_inhibit(external_trip_inhibit),
        .current_supervision_pickup(current_supervision_pickup), .source_sel(source_sel),
        .swing_block(swing_block), .swing_trip(swing_trip), .target_flag(target_flag),
        .event_pulse(event_pulse));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h, want %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_of_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test
    task automatic tmo(input logic ok);
        chk({31'h0, ok}, 32'h1);
        if (!ok) end_of_test();
    endtask : tmo
    task automatic wr(input logic [5:0] a, input logic [31:0] v);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        tmo(n < 40);
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [5:0] a);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        tmo(n < 40);
        @(posedge aclk);
    endtask : rd
    task automatic st(input logic [31:0] m, input logic [31:0] e);
        int n;
        for (n = 0; n < 60; n++) begin
            rd(ADDR_STATUS);
            if ((d & m) === e) break;
        end
        chk(d & m, e);
        if (n == 60) end_of_test();
    endtask : st

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(ADDR_CTRL);
        chk(d, 32'h4);
        rd(ADDR_SUPV);
        chk(d, 32'h258);
        rd(6'h3C);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        for (int i = 0; i < NUM_TMR; i++) wr(ADDR_DLY_BASE + ADDR_STEP * 6'(i), dly[i]);
        rd(ADDR_DLY_BASE + ADDR_STEP);
        chk(d, 32'h3);
        wr(ADDR_SUPV, 32'h32);
        chk({16'h0, current_supervision_pickup}, 32'h32);
        $display("test registers done");
        wr(ADDR_CTRL, 32'h2);
        depth <= 2'h3;
        repeat (20) @(posedge aclk);
        chk({30'h0, swing_block, swing_trip}, 32'h0);
        supv <= 1'b0;
        depth <= 2'h1;
        wr(ADDR_CTRL, 32'h503);
        repeat (20) @(posedge aclk);
        chk({30'h0, swing_block, swing_trip}, 32'h0);
        chk({29'h0, source_sel}, 32'h5);
        supv <= 1'b1;
        st(32'h5, 32'h5);
        chk({31'h0, target_flag}, 32'h1);
        depth <= 2'h2;
        st(32'h8, 32'h8);
        depth <= 2'h3;
        st(32'h12, 32'h12);
        st(32'h12, 32'h10);
        depth <= 2'h0;
        repeat (4) @(posedge aclk);
        chk({31'h0, swing_block}, 32'h1);
        st(32'h3D, 32'h0);
        $display("test early three-step done");
        wr(ADDR_CTRL, 32'h2D);
        depth <= 2'h2;
        st(32'h5, 32'h5);
        depth <= 2'h3;
        st(32'h18, 32'h10);
        depth <= 2'h1;
        st(32'h20, 32'h20);
        chk({31'h0, swing_trip}, 32'h0);
        depth <= 2'h0;
        st(32'h2, 32'h2);
        chk({31'h0, swing_trip}, 32'h1);
        external_trip_inhibit <= 1'b1;
        repeat (3) @(posedge aclk);
        chk({31'h0, swing_trip}, 32'h0);
        external_trip_inhibit <= 1'b0;
        repeat (3) @(posedge aclk);
        chk({31'h0, swing_trip}, 32'h1);
        chk(events, 32'h3);
        st(32'h3, 32'h0);
        chk({31'h0, target_flag}, 32'h1);
        wr(ADDR_STATUS, 32'h40);
        chk({30'h0, r}, {30'h0, RESP_OKAY});
        chk({31'h0, target_flag}, 32'h0);
        wr(6'h3C, 32'h0);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        $display("test delayed two-step done");
        end_of_test();
    end
endmodule : tb

`default_nettype wire
